// *** src/daa_pkg.sv ***
// Shared constants for the dual converter control block and its host end.
// Assumes one 250 MHz clock shared by both ends.
package daa_pkg;
  // ----------------------------------------
  // Device register addresses (3-bit field)
  // ----------------------------------------
  localparam logic [2:0] ADDR_CFG1 = 3'h1;
  localparam logic [2:0] ADDR_CFG2 = 3'h2;
  localparam logic [2:0] ADDR_ALERT = 3'h3;
  localparam logic [2:0] ADDR_HI = 3'h4;
  localparam logic [2:0] ADDR_LO = 3'h5;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG1_AVG_MODE = 9;
  localparam int CFG1_RATIO_LSB = 6;
  localparam int CFG1_BOOST = 5;
  localparam int CFG1_ALERT_EN = 4;
  localparam int CFG1_REF_SEL = 3;
  localparam int CFG1_POWER_MODE_BIT = 2;
  localparam int CFG2_LANE = 8;
  localparam int ALERT_SETUP_FAIL = 4;
  // ----------------------------------------
  // Reset values and reset codes
  // ----------------------------------------
  localparam logic [11:0] CFG1_RESET = 12'h000;
  localparam logic [11:0] HI_RESET = 12'hFFF;
  localparam logic [11:0] LO_RESET = 12'h000;
  localparam logic [7:0] RESET_SOFT = 8'h3C;
  localparam logic [7:0] RESET_HARD = 8'hFF;
  // ----------------------------------------
  // Result widths
  // ----------------------------------------
  localparam logic [4:0] BITS_WIDE = 5'h10;
  localparam logic [4:0] BITS_NARROW = 5'h0E;
  localparam logic [4:0] BITS_BOOST = 5'h02;
  // ----------------------------------------
  // Host APB map and frame timing
  // ----------------------------------------
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STAT = 8'h04;
  localparam int HOST_BUSY = 16;
  localparam int HOST_FLAG = 17;
  localparam real FRAME_NS = 16.0;
  localparam real CLK_NS = 4.0;
  localparam int FRAME_CYC = int'(FRAME_NS / CLK_NS);
  typedef enum logic [1:0] {ST_RUN = 2'b00, ST_TEST = 2'b01} daa_state_e;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_FRAME = 2'b01, H_GAP = 2'b10} daa_host_e;
endpackage

// *** src/daa_link_if.sv ***
// Link between the converter control end and its serial master end.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface daa_link_if;
  logic cs_n;
  logic cmd_write;
  logic [2:0] cmd_addr;
  logic [11:0] cmd_data;
  logic [15:0] rd_data;
  logic rd_valid;
  logic flag_pin;
  modport dev (input cs_n, input cmd_write, input cmd_addr, input cmd_data,
    output rd_data, output rd_valid, output flag_pin);
  modport host (output cs_n, output cmd_write, output cmd_addr, output cmd_data,
    input rd_data, input rd_valid, input flag_pin);
endinterface

// *** src/daa_limit_cmp.sv ***
// Per-channel limit comparator at the presented result width.
// Assumes results arrive MSB aligned in 18 bits.
`timescale 1ns/1ps
module daa_limit_cmp
  import daa_pkg::*;
(
  input wire logic [17:0] result,
  input wire logic [4:0] bits,
  input wire logic [11:0] hi_lim,
  input wire logic [11:0] lo_lim,
  output logic over,
  output logic under
);
  logic [17:0] shown;
  // Drop the bits that are not presented
  assign shown = result & ~(18'h3_FFFF >> bits);
  assign over = shown > {hi_lim, 6'h3F};
  assign under = shown < {lo_lim, 6'h00};
endmodule

// *** src/daa_device.sv ***
// Control and status end of the dual converter: config, alert, power, reset.
// Assumes the analog core pulses CONV_DONE with MSB aligned results.
// Behaviour
// - Result 16/14 bits, boosted 18/16
// - Host clocks 18/16 bits when boosted
// - Rolling ratio codes 0-3: none,2,4,8
// - Alert when result above high, below low
// - One limit pair shared by both channels
// - Host keeps high limit above low
// - Two alert flags per channel
// - OR of flags drives shared flag pin
// - Host sets lane, enable, limits for alert
// - Flags and pin update at conversion end
// - Host reads flags before next conversion
// - Frame start clears pin; reset clears flags
// - Power bit: 0 normal, 1 shutdown
// - Shutdown powers analog off, link stays
// - Shutdown keeps all configuration
// - Host waits for settling after shutdown
// - Reference bit: 0 internal, 1 external
// - Reset field write starts soft or hard
// - Soft reset flushes state, clears alerts
// - Hard reset also restores defaults, oscillator
// - Self test after reset reports setup fail
// - Host hard resets on setup fail
// - Oversampling valid needs nonzero ratio
`timescale 1ns/1ps
module daa_device
  import daa_pkg::*;
#(
  parameter bit WIDE = 1'b1
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  daa_link_if.dev LINK,
  input wire logic CONV_DONE,
  input wire logic [17:0] RESULT_A,
  input wire logic [17:0] RESULT_B,
  input wire logic SELF_TEST_FAIL,
  output logic CONV_START,
  output logic [4:0] RESULT_BITS,
  output logic [5:0] AVG_COUNT,
  output logic AVG_ROLLING,
  output logic EVERY_CONV,
  output logic ANALOG_ON,
  output logic REF_BUF_ON,
  output logic OSC_RESET,
  output logic AVG_FLUSH,
  output logic ALERT_ANY
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [11:0] cfg1;
  logic lane_sel;
  logic [11:0] hi_lim;
  logic [11:0] lo_lim;
  logic [3:0] flags;
  logic setup_fail;
  logic cs_q;
  daa_state_e state;
  logic frame_start;
  logic wr_hit;
  logic soft_rst;
  logic hard_rst;
  logic [2:0] ratio;
  logic os_valid;
  logic [4:0] next_bits;
  logic [5:0] next_count;
  logic [1:0] over;
  logic [1:0] under;
  logic [3:0] next_flags;

  assign frame_start = cs_q && !LINK.cs_n;
  assign wr_hit = frame_start && LINK.cmd_write;
  assign soft_rst = wr_hit && LINK.cmd_addr == ADDR_CFG2
    && LINK.cmd_data[7:0] == RESET_SOFT;
  assign hard_rst = wr_hit && LINK.cmd_addr == ADDR_CFG2
    && LINK.cmd_data[7:0] == RESET_HARD;
  assign ratio = cfg1[CFG1_RATIO_LSB +: 3];
  assign os_valid = ratio != 3'h0;

  // ----------------------------------------
  // Result width and averaging decode
  // ----------------------------------------
  always_comb begin
    next_bits = WIDE ? BITS_WIDE : BITS_NARROW;
    if (cfg1[CFG1_BOOST] && os_valid) begin
      next_bits = next_bits + BITS_BOOST;
    end
  end

  always_comb begin
    next_count = 6'h01;
    if (cfg1[CFG1_AVG_MODE]) begin
      // Rolling store holds eight samples, so larger codes stop at eight
      case (ratio)
        3'h0: next_count = 6'h01;
        3'h1: next_count = 6'h02;
        3'h2: next_count = 6'h04;
        default: next_count = 6'h08;
      endcase
    end else begin
      case (ratio)
        3'h0: next_count = 6'h01;
        3'h6: next_count = 6'h20;
        3'h7: next_count = 6'h20;
        default: next_count = 6'(6'h01 << ratio);
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RESULT_BITS <= BITS_NARROW;
      AVG_COUNT <= 6'h01;
      AVG_ROLLING <= 1'b0;
      EVERY_CONV <= 1'b1;
    end else begin
      RESULT_BITS <= next_bits;
      AVG_COUNT <= next_count;
      AVG_ROLLING <= cfg1[CFG1_AVG_MODE];
      // Rolling keeps the full output rate at every code
      EVERY_CONV <= cfg1[CFG1_AVG_MODE] || !os_valid;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Power changes never touch these, only RST and the hard reset do
  always_ff @(posedge SYS_CLK) begin
    if (RST || hard_rst) begin
      cfg1 <= CFG1_RESET;
      lane_sel <= 1'b0;
      hi_lim <= HI_RESET;
      lo_lim <= LO_RESET;
    end else if (wr_hit) begin
      case (LINK.cmd_addr)
        ADDR_CFG1: cfg1 <= LINK.cmd_data;
        ADDR_CFG2: lane_sel <= LINK.cmd_data[CFG2_LANE];
        ADDR_HI: hi_lim <= LINK.cmd_data;
        ADDR_LO: lo_lim <= LINK.cmd_data;
        default: cfg1 <= cfg1;
      endcase
    end
  end

  // ----------------------------------------
  // Limit comparison, one per channel
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      daa_limit_cmp u_cmp (
        .result(ch == 0 ? RESULT_A : RESULT_B),
        .bits(next_bits),
        .hi_lim(hi_lim),
        .lo_lim(lo_lim),
        .over(over[ch]),
        .under(under[ch])
      );
      assign next_flags[2 * ch] = under[ch];
      assign next_flags[2 * ch + 1] = over[ch];
    end
  endgenerate

  // ----------------------------------------
  // Alert flags and flag pin
  // ----------------------------------------
  // A finishing conversion beats a flag clear in the same cycle; at the pin and ALERT_ANY a hard reset beats it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      flags <= 4'h0;
    end else if (CONV_DONE) begin
      flags <= next_flags;
    end else if (soft_rst || hard_rst) begin
      flags <= 4'h0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST || hard_rst) begin
      ALERT_ANY <= 1'b0;
      LINK.flag_pin <= 1'b0;
    end else if (CONV_DONE) begin
      ALERT_ANY <= |next_flags;
      LINK.flag_pin <= lane_sel && cfg1[CFG1_ALERT_EN] && |next_flags;
    end else if (frame_start) begin
      ALERT_ANY <= 1'b0;
      LINK.flag_pin <= 1'b0;
    end
  end

  // ----------------------------------------
  // Frame edge, conversion start, readback
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cs_q <= 1'b1;
      CONV_START <= 1'b0;
    end else if (soft_rst || hard_rst) begin
      // Track the low line so one reset command never fires again
      cs_q <= 1'b0;
      CONV_START <= 1'b0;
    end else begin
      cs_q <= LINK.cs_n;
      // No conversion while powered down
      CONV_START <= frame_start && !cfg1[CFG1_POWER_MODE_BIT] && state == ST_RUN;
    end
  end

  // Link stays alive in shutdown so the exit write can land
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      LINK.rd_valid <= 1'b0;
      LINK.rd_data <= 16'h0000;
    end else begin
      LINK.rd_valid <= frame_start && !LINK.cmd_write;
      if (frame_start && !LINK.cmd_write) begin
        case (LINK.cmd_addr)
          ADDR_CFG1: LINK.rd_data <= {4'h0, cfg1};
          ADDR_CFG2: LINK.rd_data <= {7'h00, lane_sel, 8'h00};
          ADDR_ALERT: LINK.rd_data <= {11'h000, setup_fail, flags};
          ADDR_HI: LINK.rd_data <= {4'h0, hi_lim};
          ADDR_LO: LINK.rd_data <= {4'h0, lo_lim};
          default: LINK.rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Power, reference, reset pulses
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ANALOG_ON <= 1'b0;
      REF_BUF_ON <= 1'b0;
      OSC_RESET <= 1'b1;
      AVG_FLUSH <= 1'b1;
    end else begin
      ANALOG_ON <= !cfg1[CFG1_POWER_MODE_BIT];
      REF_BUF_ON <= !cfg1[CFG1_POWER_MODE_BIT] && !cfg1[CFG1_REF_SEL];
      OSC_RESET <= hard_rst;
      AVG_FLUSH <= soft_rst || hard_rst;
    end
  end

  // ----------------------------------------
  // Self test after power-on or hard reset
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= ST_TEST;
      setup_fail <= 1'b0;
    end else begin
      case (state)
        ST_TEST: begin
          setup_fail <= SELF_TEST_FAIL;
          state <= ST_RUN;
        end
        ST_RUN: begin
          if (hard_rst) begin
            setup_fail <= 1'b0;
            state <= ST_TEST;
          end
        end
        default: state <= ST_TEST;
      endcase
    end
  end
endmodule

// *** src/daa_host.sv ***
// Serial master end: APB orders become framed register commands.
// Assumes software keeps the limit order and waits after shutdown.
`timescale 1ns/1ps
module daa_host
  import daa_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  daa_link_if.host LINK
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  daa_host_e state;
  logic [3:0] cnt;
  logic [15:0] rdata;
  logic take;
  logic go;

  assign take = PSEL && PENABLE && PREADY;
  // Orders during a frame are dropped; software polls busy first
  assign go = take && PWRITE && PADDR == HOST_CMD && state == H_IDLE;

  // ----------------------------------------
  // APB slave, one wait-free access phase
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      if (PSEL && !PENABLE && PADDR == HOST_STAT) begin
        PRDATA <= {14'h0000, LINK.flag_pin, state != H_IDLE, rdata};
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= H_IDLE;
      cnt <= 4'h0;
      rdata <= 16'h0000;
      LINK.cs_n <= 1'b1;
      LINK.cmd_write <= 1'b0;
      LINK.cmd_addr <= 3'h0;
      LINK.cmd_data <= 12'h000;
    end else begin
      case (state)
        H_IDLE: begin
          if (go) begin
            LINK.cs_n <= 1'b0;
            LINK.cmd_write <= PWDATA[15];
            LINK.cmd_addr <= PWDATA[14:12];
            LINK.cmd_data <= PWDATA[11:0];
            cnt <= 4'(FRAME_CYC - 1);
            state <= H_FRAME;
          end
        end
        H_FRAME: begin
          if (LINK.rd_valid) begin
            rdata <= LINK.rd_data;
          end
          if (cnt == 4'h0) begin
            LINK.cs_n <= 1'b1;
            state <= H_GAP;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        H_GAP: state <= H_IDLE;
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

// *** dv/daa_link_props.sv ***
// Checker on the link between the converter control end and its master end.
// Assumes the bench never pulses CONV_DONE on a frame start edge.
`timescale 1ns/1ps
module daa_link_props
  import daa_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic cs_n,
  input wire logic cmd_write,
  input wire logic [2:0] cmd_addr,
  input wire logic [11:0] cmd_data,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic flag_pin
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Shadow of written settings
  // ----------------------------------------
  logic cs_q;
  logic start;
  logic wr_go;
  logic hard;
  logic sh_lane;
  logic [11:0] sh_cfg1, sh_hi, sh_lo;
  assign start = !cs_n && cs_q;
  assign wr_go = start && cmd_write;
  assign hard = wr_go && cmd_addr == ADDR_CFG2 && cmd_data[7:0] == RESET_HARD;
  always_ff @(posedge SYS_CLK) begin
    cs_q <= RST ? 1'b1 : cs_n;
  end
  // Soft reset keeps settings, so only a hard code restores the shadow
  always_ff @(posedge SYS_CLK) begin
    if (RST || hard) begin
      sh_cfg1 <= CFG1_RESET;
      sh_hi <= HI_RESET;
      sh_lo <= LO_RESET;
      sh_lane <= 1'b0;
    end else if (wr_go) begin
      if (cmd_addr == ADDR_CFG1) sh_cfg1 <= cmd_data;
      if (cmd_addr == ADDR_CFG2) sh_lane <= cmd_data[CFG2_LANE];
      if (cmd_addr == ADDR_HI) sh_hi <= cmd_data;
      if (cmd_addr == ADDR_LO) sh_lo <= cmd_data;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  frame_len_a: assert property (
    $fell(cs_n) |-> !cs_n [*4] ##1 cs_n) else $error("frame length wrong");
  cmd_hold_a: assert property (
    !cs_n && !$fell(cs_n) |-> $stable(cmd_addr) && $stable(cmd_data) && $stable(cmd_write))
    else $error("command moved in frame");
  frame_gap_a: assert property ($rose(cs_n) |=> cs_n) else $error("no frame gap");
  rd_cause_a: assert property (
    rd_valid |-> $past(start && !cmd_write)) else $error("read data without read");
  cfg_keep_a: assert property (
    rd_valid && $past(cmd_addr) == ADDR_CFG1 |-> rd_data == {4'h0, sh_cfg1})
    else $error("config read mismatch");
  high_lim_a: assert property (
    rd_valid && $past(cmd_addr) == ADDR_HI |-> rd_data[11:0] == sh_hi)
    else $error("high limit read mismatch");
  low_lim_a: assert property (
    rd_valid && $past(cmd_addr) == ADDR_LO |-> rd_data[11:0] == sh_lo)
    else $error("low limit read mismatch");
  lane_keep_a: assert property (
    rd_valid && $past(cmd_addr) == ADDR_CFG2 |-> rd_data[CFG2_LANE] == sh_lane)
    else $error("lane read mismatch");
  alert_fmt_a: assert property (
    rd_valid && $past(cmd_addr) == ADDR_ALERT |-> rd_data[15:5] == 11'h000)
    else $error("alert spare bits set");
  pin_gate_a: assert property (
    !(sh_lane && sh_cfg1[CFG1_ALERT_EN]) |-> !flag_pin) else $error("pin not gated");
  pin_clear_a: assert property (start |=> !flag_pin) else $error("pin kept");
endmodule

// *** dv/dual_adc_alert_power_reset_ctrl_tb.sv ***
// Bench for the converter control end joined to its APB master end.
// Assumes zero wait APB and one frame per device command.
`timescale 1ns/1ps
module dual_adc_alert_power_reset_ctrl_tb
  import daa_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_done = 1'b0, st_fail = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [17:0] res_a = 18'h0_0000, res_b = 18'h0_0000;
  logic [31:0] prdata;
  logic pready, conv_start, avg_roll, every_conv, analog_on, ref_on, osc_rst, flush, alert_any;
  logic [4:0] res_bits;
  logic [5:0] avg_count;
  int num_errors = 0, comparisons = 0, starts = 0, osc_n = 0, flush_n = 0, s0;
  logic [17:0] va [3] = '{18'h2_0040, 18'h2_003F, 18'h0_0000};
  logic [17:0] vb [3] = '{18'h0_FFFC, 18'h1_0000, 18'h3_FFFF};
  logic [15:0] ve [3] = '{16'h0006, 16'h0000, 16'h0009};
  always #2 sys_clk = ~sys_clk;
  daa_link_if link();
  daa_device u_daa_device (.SYS_CLK(sys_clk), .RST(rst), .LINK(link.dev),
    .CONV_DONE(conv_done), .RESULT_A(res_a), .RESULT_B(res_b), .SELF_TEST_FAIL(st_fail),
    .CONV_START(conv_start), .RESULT_BITS(res_bits), .AVG_COUNT(avg_count),
    .AVG_ROLLING(avg_roll), .EVERY_CONV(every_conv), .ANALOG_ON(analog_on),
    .REF_BUF_ON(ref_on), .OSC_RESET(osc_rst), .AVG_FLUSH(flush), .ALERT_ANY(alert_any));
  daa_host u_daa_host (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(), .LINK(link.host));
  daa_link_props u_daa_link_props (.SYS_CLK(sys_clk), .RST(rst), .cs_n(link.cs_n),
    .cmd_write(link.cmd_write), .cmd_addr(link.cmd_addr), .cmd_data(link.cmd_data),
    .rd_data(link.rd_data), .rd_valid(link.rd_valid), .flag_pin(link.flag_pin));
  // Pulse counters, read as deltas around one command
  always @(posedge sys_clk) begin
    if (!rst && conv_start === 1'b1) starts++;
    if (!rst && osc_rst === 1'b1) osc_n++;
    if (!rst && flush === 1'b1) flush_n++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // Poll busy so the frame is over before the next order
  task automatic cmd(input logic w, input logic [2:0] a, input logic [11:0] d,
      output logic [15:0] q);
    logic [31:0] r;
    int n;
    apb(1'b1, HOST_CMD, {16'h0000, w, a, d}, r);
    n = 0;
    do begin
      apb(1'b0, HOST_STAT, 32'h0000_0000, r);
      n++;
    end while (r[HOST_BUSY] !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      report_and_stop();
    end
    q = r[15:0];
  endtask
  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    logic [15:0] q;
    cmd(1'b1, a, d, q);
  endtask
  task automatic rdchk(input string nm, input logic [2:0] a, input logic [15:0] e);
    logic [15:0] q;
    cmd(1'b0, a, 12'h000, q);
    chk(nm, 32'(q), 32'(e));
  endtask
  // Host is idle here, so the pulse never meets a frame start
  task automatic conv(input logic [17:0] a, input logic [17:0] b);
    @(posedge sys_clk);
    res_a <= a;
    res_b <= b;
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk("cfg1", ADDR_CFG1, {4'h0, CFG1_RESET});
    rdchk("high", ADDR_HI, {4'h0, HI_RESET});
    rdchk("alert", ADDR_ALERT, 16'h0000);
    chk("bits", 32'(res_bits), 32'(BITS_WIDE));
    chk("analog", 32'(analog_on), 32'h1);
    chk("refbuf", 32'(ref_on), 32'h1);
    for (int k = 0; k < 4; k++) begin
      s0 = starts;
      wr(ADDR_CFG1, 12'h220 | (12'(k) << CFG1_RATIO_LSB));
      chk("bits", 32'(res_bits), 32'(k == 0 ? BITS_WIDE : BITS_WIDE + BITS_BOOST));
      chk("count", 32'(avg_count), 32'(1 << k));
      chk("every", 32'(every_conv), 32'h1);
      chk("rate", 32'(starts - s0), 32'h1);
      chk("roll", 32'(avg_roll), 32'h1);
    end
    wr(ADDR_CFG1, 12'h0C0);
    chk("normal", 32'(every_conv), 32'h0);
    chk("ncount", 32'(avg_count), 32'h8);
    chk("nroll", 32'(avg_roll), 32'h0);
    wr(ADDR_HI, 12'h800);
    wr(ADDR_LO, 12'h400);
    wr(ADDR_CFG2, 12'h100);
    wr(ADDR_CFG1, 12'h010);
    for (int k = 0; k < 3; k++) begin
      conv(va[k], vb[k]);
      chk("pin", 32'(link.flag_pin), 32'(ve[k] != 0));
      chk("any", 32'(alert_any), 32'(ve[k] != 0));
      rdchk("alert", ADDR_ALERT, ve[k]);
      chk("pin", 32'(link.flag_pin), 32'h0);
    end
    wr(ADDR_CFG1, 12'h000);
    conv(18'h3_FFFF, 18'h0_0000);
    chk("gated", 32'(link.flag_pin), 32'h0);
    chk("any", 32'(alert_any), 32'h1);
    s0 = flush_n;
    wr(ADDR_CFG2, 12'h13C);
    rdchk("alert", ADDR_ALERT, 16'h0000);
    rdchk("high", ADDR_HI, 16'h0800);
    chk("flush", 32'(flush_n - s0), 32'h1);
    chk("analog", 32'(analog_on), 32'h1);
    wr(ADDR_CFG1, 12'h004);
    chk("analog", 32'(analog_on), 32'h0);
    chk("refbuf", 32'(ref_on), 32'h0);
    s0 = starts;
    rdchk("cfg1", ADDR_CFG1, 16'h0004);
    chk("noconv", 32'(starts - s0), 32'h0);
    rdchk("low", ADDR_LO, 16'h0400);
    wr(ADDR_CFG1, 12'h008);
    chk("analog", 32'(analog_on), 32'h1);
    chk("refbuf", 32'(ref_on), 32'h0);
    // Settling time before the next conversion
    repeat (8) @(posedge sys_clk);
    s0 = starts;
    rdchk("cfg1", ADDR_CFG1, 16'h0008);
    chk("conv", 32'(starts - s0), 32'h1);
    st_fail <= 1'b1;
    s0 = osc_n;
    wr(ADDR_CFG2, 12'h0FF);
    chk("osc", 32'(osc_n - s0), 32'h1);
    rdchk("alert", ADDR_ALERT, 16'h0010);
    rdchk("high", ADDR_HI, {4'h0, HI_RESET});
    rdchk("cfg2", ADDR_CFG2, 16'h0000);
    chk("refbuf", 32'(ref_on), 32'h1);
    st_fail <= 1'b0;
    wr(ADDR_CFG2, 12'h0FF);
    rdchk("alert", ADDR_ALERT, 16'h0000);
    report_and_stop();
  end
endmodule
